/* File: src/vic_top.v */
// Vectored interrupt controller with APB register file and two time bases
// Notes on behaviour
// (R1) Vector a pin interrupt when enabled, stack not full, selected edge seen.
// (R2) Servicing a pin interrupt clears its flag and the global enable.
// (R3) Edge select per pin: rising, falling, both, or disabled.
// (R4) A group flag sets whenever any member source flag becomes set.
// (R5) Vector a group when enabled, stack not full, any member requests.
// (R6) Servicing a group clears only the group flag and global enable.
// (R7) Software clears group member flags itself; service never clears them.
// (R8) Each timer has A-match and P-match flags with their own enables.
// (R9) Timer match vectors only with global, source and group enables set.
// (R10) Supply-low flag sets on low report; vectors with global, source, group enables.
// (R11) Supply-low flag stays set after group service until software clears.
// (R12) Write-done flag sets at write end; vectors with global, source, group enables.
// (R13) Write-done flag stays set after service until software clears.
// (R14) SPI or I2C events set the serial module flag.
// (R15) Six UART events set the serial module flag.
// (R16) Serial module needs global and own enable; service clears flag and global.
// (R17) Service leaves UART status flags alone.
// (R18) Second serial flag sets per byte; vectors with global and own enable.
// (R19) Servicing second serial clears its flag and global enable.
// (R20) Each period flag sets on its divider overflow; needs global and own enable.
// (R21) Servicing a period interrupt clears its flag and global enable.
// (R22) Period clock is crystal over eight, then a selectable divider.
// (R23) Any flag rising wakes the device regardless of enables.
// (R24) Return-from-irq sets global enable; plain return leaves it clear.
// (R25) Simultaneous requests: one vector granted by fixed priority, rest pending.
// (R26) Flags latch even when disabled and hold until serviced or cleared.
`timescale 1ns/1ns
`include "vic_consts.vh"
module vic_top (
   // APB slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire [31:0] prdata,
   output wire pready,
   output wire pslverr,
   // External interrupt pins
   input wire [3:0] irq_pin,
   // Peripheral event pulses
   input wire [5:0] tmr_match_evt,
   input wire supply_low_evt,
   input wire nvm_write_done_evt,
   input wire [3:0] serial_sync_evt,
   input wire [5:0] uart_evt,
   input wire second_serial_evt,
   input wire low_speed_crystal_tick,
   // CPU core sequencer
   input wire stack_full,
   input wire irq_ack,
   input wire return_from_irq_instr,
   output reg irq_req,
   output reg [3:0] irq_vector,
   output reg wake_up
);
   // ****************************************************************
   // Registers
   // ****************************************************************
   reg global_irq_enable_r;
   reg [3:0] pin_irq_flags_r;
   reg [3:0] pin_irq_enables_r;
   reg serial_module_flag_r;
   reg serial_module_enable_r;
   reg second_serial_flag_r;
   reg second_serial_enable_r;
   reg [2:0] group_irq_flag_r;
   reg [2:0] group_irq_enable_r;
   reg period0_flag_r;
   reg period1_flag_r;
   reg period0_enable_r;
   reg period1_enable_r;
   reg [5:0] tmr_flag_r;
   reg [5:0] tmr_enable_r;
   reg supply_low_flag_r;
   reg supply_low_enable_r;
   reg nvm_write_done_flag_r;
   reg nvm_write_done_enable_r;
   reg [7:0] edge_select_reg_r;
   reg [7:0] period0_control_reg_r;
   reg [7:0] period1_control_reg_r;
   reg [1:0] psc_en_r;
   reg [3:0] pin_prev_r;
   reg [2:0] xtal_div_r;
   reg [14:0] per0_cnt_r;
   reg [14:0] per1_cnt_r;
   reg [31:0] prdata_r;
   reg [31:0] flags_prev_r;
   // ****************************************************************
   // Helper functions
   // ****************************************************************
   // Edge match for one pin under its two-bit select
   function edge_hit;
      input [1:0] sel;
      input prev;
      input cur;
      begin
         case (sel)
            `VIC_EDGE_RISE: edge_hit = ~prev & cur;
            `VIC_EDGE_FALL: edge_hit = prev & ~cur;
            `VIC_EDGE_BOTH: edge_hit = prev ^ cur;
            default: edge_hit = 1'b0;
         endcase
      end
   endfunction
   // Overflow of a period counter at the selected bit width
   function per_ovf;
      input [14:0] cnt;
      input [2:0] sel;
      reg [15:0] lim;
      begin
         lim = 16'h0000;
         lim = (16'h0001 << (`VIC_PER_BASE_LOG2 + sel)) - 16'h0001;
         per_ovf = ({1'b0, cnt} >= lim);
      end
   endfunction
   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire wr_en = psel & penable & pwrite;
   wire rd_en = psel & penable & ~pwrite;
   wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= `VIC_VEC_OFS);
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;
   assign prdata = prdata_r;
   wire wr_ctrl0 = wr_en && (paddr == `VIC_CTRL0_OFS);
   wire wr_ctrl1 = wr_en && (paddr == `VIC_CTRL1_OFS);
   wire wr_ctrl2 = wr_en && (paddr == `VIC_CTRL2_OFS);
   wire wr_grp0 = wr_en && (paddr == `VIC_GRP0_OFS);
   wire wr_grp1 = wr_en && (paddr == `VIC_GRP1_OFS);
   wire wr_grp2 = wr_en && (paddr == `VIC_GRP2_OFS);
   // ****************************************************************
   // Event detection
   // ****************************************************************
   // (R3) per-pin edge select
   wire [3:0] pin_evt;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
         assign pin_evt[gi] = edge_hit(edge_select_reg_r[2*gi+1:2*gi], pin_prev_r[gi], irq_pin[gi]);
      end
   endgenerate
   // (R14) (R15) serial events merge; (R17) UART status is never touched here
   wire ser_evt = (|serial_sync_evt) | (|uart_evt);
   // (R22) crystal over eight, then the selected divider
   wire psc_tick = low_speed_crystal_tick && (xtal_div_r == `VIC_XTAL_PRE_DIV);
   wire per0_run = period0_control_reg_r[7] & psc_en_r[0];
   wire per1_run = period1_control_reg_r[7] & psc_en_r[1];
   wire per0_evt = per0_run & psc_tick & per_ovf(per0_cnt_r, period0_control_reg_r[2:0]);
   wire per1_evt = per1_run & psc_tick & per_ovf(per1_cnt_r, period1_control_reg_r[2:0]);
   // ****************************************************************
   // Request and priority
   // ****************************************************************
   // (R9) (R10) (R12) member requests need source enables
   wire [2:0] grp_member_req;
   assign grp_member_req[0] = |(tmr_flag_r[3:0] & tmr_enable_r[3:0]);
   assign grp_member_req[1] = |(tmr_flag_r[5:4] & tmr_enable_r[5:4]);
   assign grp_member_req[2] = (supply_low_flag_r & supply_low_enable_r) |
      (nvm_write_done_flag_r & nvm_write_done_enable_r);
   wire [10:0] pend;
   assign pend = {pin_irq_flags_r[3] & pin_irq_enables_r[3],
      pin_irq_flags_r[2] & pin_irq_enables_r[2],
      period1_flag_r & period1_enable_r,
      period0_flag_r & period0_enable_r,
      group_irq_flag_r & group_irq_enable_r & grp_member_req,
      second_serial_flag_r & second_serial_enable_r,
      serial_module_flag_r & serial_module_enable_r,
      pin_irq_flags_r[1] & pin_irq_enables_r[1],
      pin_irq_flags_r[0] & pin_irq_enables_r[0]};
   // (R25) fixed priority, lowest index first
   reg [3:0] win_idx;
   integer k;
   always @* begin
      win_idx = 4'h0;
      for (k = `VIC_NUM_VEC - 1; k >= 0; k = k - 1) begin
         if (pend[k]) begin
            win_idx = k[3:0];
         end
      end
   end
   // (R1) (R5) request only with global enable and stack room
   wire req_nxt = global_irq_enable_r & ~stack_full & (|pend);
   wire svc = irq_ack & irq_req;
   wire [10:0] svc_hot = svc ? (11'h001 << irq_vector) : 11'h000;
   // Request output registered so the vector is stable when the core acks
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req <= 1'b0;
         irq_vector <= 4'h0;
      end else begin
         irq_req <= req_nxt & ~svc;
         irq_vector <= win_idx;
      end
   end
   // ****************************************************************
   // Flags and enables
   // ****************************************************************
   // Set beats clear in every flag below
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         global_irq_enable_r <= 1'b0;
         pin_irq_flags_r <= 4'h0;
         pin_irq_enables_r <= 4'h0;
         serial_module_flag_r <= 1'b0;
         serial_module_enable_r <= 1'b0;
         second_serial_flag_r <= 1'b0;
         second_serial_enable_r <= 1'b0;
         group_irq_flag_r <= 3'h0;
         group_irq_enable_r <= 3'h0;
         period0_flag_r <= 1'b0;
         period1_flag_r <= 1'b0;
         period0_enable_r <= 1'b0;
         period1_enable_r <= 1'b0;
         tmr_flag_r <= 6'h00;
         tmr_enable_r <= 6'h00;
         supply_low_flag_r <= 1'b0;
         supply_low_enable_r <= 1'b0;
         nvm_write_done_flag_r <= 1'b0;
         nvm_write_done_enable_r <= 1'b0;
      end else begin
         // (R2) (R6) (R16) (R19) (R21) service drops global enable; (R24) return restores it
         if (svc) begin
            global_irq_enable_r <= 1'b0;
         end else if (return_from_irq_instr) begin
            global_irq_enable_r <= 1'b1;
         end else if (wr_ctrl0) begin
            global_irq_enable_r <= pwdata[0];
         end
         if (wr_ctrl0) begin
            pin_irq_enables_r[1:0] <= pwdata[2:1];
            serial_module_enable_r <= pwdata[3];
         end
         if (wr_ctrl1) begin
            second_serial_enable_r <= pwdata[0];
            group_irq_enable_r <= pwdata[3:1];
         end
         if (wr_ctrl2) begin
            period0_enable_r <= pwdata[0];
            period1_enable_r <= pwdata[1];
            pin_irq_enables_r[3:2] <= pwdata[3:2];
         end
         if (wr_grp0) begin
            tmr_enable_r[3:0] <= pwdata[3:0];
         end
         if (wr_grp1) begin
            tmr_enable_r[5:4] <= pwdata[1:0];
         end
         if (wr_grp2) begin
            supply_low_enable_r <= pwdata[0];
            nvm_write_done_enable_r <= pwdata[1];
         end
         // (R1) (R2) (R26) pin flags
         pin_irq_flags_r[1:0] <= pin_evt[1:0] | (wr_ctrl0 ? pwdata[5:4] : (pin_irq_flags_r[1:0] & ~svc_hot[1:0]));
         pin_irq_flags_r[3:2] <= pin_evt[3:2] | (wr_ctrl2 ? pwdata[7:6] : (pin_irq_flags_r[3:2] & ~svc_hot[10:9]));
         // (R16) serial module flag
         serial_module_flag_r <= ser_evt | (wr_ctrl0 ? pwdata[6] : (serial_module_flag_r & ~svc_hot[2]));
         // (R18) (R19) second serial flag
         second_serial_flag_r <= second_serial_evt | (wr_ctrl1 ? pwdata[4] : (second_serial_flag_r & ~svc_hot[3]));
         // (R20) (R21) period flags
         period0_flag_r <= per0_evt | (wr_ctrl2 ? pwdata[4] : (period0_flag_r & ~svc_hot[7]));
         period1_flag_r <= per1_evt | (wr_ctrl2 ? pwdata[5] : (period1_flag_r & ~svc_hot[8]));
         // (R4) (R6) group flags follow member flag sets, clear on service
         group_irq_flag_r <= {supply_low_evt | nvm_write_done_evt, |tmr_match_evt[5:4], |tmr_match_evt[3:0]} |
            (wr_ctrl1 ? pwdata[7:5] : (group_irq_flag_r & ~svc_hot[6:4]));
         // (R7) (R8) (R11) (R13) member flags: only software clears
         tmr_flag_r[3:0] <= tmr_match_evt[3:0] | (wr_grp0 ? pwdata[7:4] : tmr_flag_r[3:0]);
         tmr_flag_r[5:4] <= tmr_match_evt[5:4] | (wr_grp1 ? pwdata[5:4] : tmr_flag_r[5:4]);
         supply_low_flag_r <= supply_low_evt | (wr_grp2 ? pwdata[4] : supply_low_flag_r);
         nvm_write_done_flag_r <= nvm_write_done_evt | (wr_grp2 ? pwdata[5] : nvm_write_done_flag_r);
      end
   end
   // ****************************************************************
   // Configuration, time base and wake
   // ****************************************************************
   wire [31:0] flags_now = {7'h00, tmr_flag_r, supply_low_flag_r, nvm_write_done_flag_r, group_irq_flag_r,
      period1_flag_r, period0_flag_r, second_serial_flag_r, serial_module_flag_r, pin_irq_flags_r, 6'h00};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         edge_select_reg_r <= `VIC_RESET_VAL;
         period0_control_reg_r <= `VIC_RESET_VAL;
         period1_control_reg_r <= `VIC_RESET_VAL;
         psc_en_r <= 2'h0;
         pin_prev_r <= 4'h0;
         xtal_div_r <= 3'h0;
         per0_cnt_r <= 15'h0000;
         per1_cnt_r <= 15'h0000;
         flags_prev_r <= 32'h00000000;
         wake_up <= 1'b0;
      end else begin
         pin_prev_r <= irq_pin;
         if (wr_en && paddr == `VIC_EDGE_OFS) begin
            edge_select_reg_r <= pwdata[7:0];
         end
         if (wr_en && paddr == `VIC_PER0_OFS) begin
            period0_control_reg_r <= pwdata[7:0] & 8'h87;
         end
         if (wr_en && paddr == `VIC_PER1_OFS) begin
            period1_control_reg_r <= pwdata[7:0] & 8'h87;
         end
         if (wr_en && paddr == `VIC_PSC_OFS) begin
            psc_en_r <= pwdata[1:0];
         end
         // (R22) prescaler of eight crystal ticks
         if (low_speed_crystal_tick) begin
            xtal_div_r <= xtal_div_r + 3'h1;
         end
         // Counters restart when stopped; the prescaler runs free, so the first period after an enable can be up to seven crystal ticks short
         if (!per0_run) begin
            per0_cnt_r <= 15'h0000;
         end else if (psc_tick) begin
            per0_cnt_r <= per0_evt ? 15'h0000 : per0_cnt_r + 15'h0001;
         end
         if (!per1_run) begin
            per1_cnt_r <= 15'h0000;
         end else if (psc_tick) begin
            per1_cnt_r <= per1_evt ? 15'h0000 : per1_cnt_r + 15'h0001;
         end
         // (R23) rising flag wakes, enables ignored
         flags_prev_r <= flags_now;
         wake_up <= |(flags_now & ~flags_prev_r);
      end
   end
   // ****************************************************************
   // Read data
   // ****************************************************************
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `VIC_CTRL0_OFS: prdata_r <= {25'h0, serial_module_flag_r, pin_irq_flags_r[1:0], serial_module_enable_r,
               pin_irq_enables_r[1:0], global_irq_enable_r};
            `VIC_CTRL1_OFS: prdata_r <= {24'h0, group_irq_flag_r, second_serial_flag_r, group_irq_enable_r,
               second_serial_enable_r};
            `VIC_CTRL2_OFS: prdata_r <= {24'h0, pin_irq_flags_r[3:2], period1_flag_r, period0_flag_r,
               pin_irq_enables_r[3:2], period1_enable_r, period0_enable_r};
            `VIC_GRP0_OFS: prdata_r <= {24'h0, tmr_flag_r[3:0], tmr_enable_r[3:0]};
            `VIC_GRP1_OFS: prdata_r <= {26'h0, tmr_flag_r[5:4], 2'h0, tmr_enable_r[5:4]};
            `VIC_GRP2_OFS: prdata_r <= {26'h0, nvm_write_done_flag_r, supply_low_flag_r, 2'h0,
               nvm_write_done_enable_r, supply_low_enable_r};
            `VIC_EDGE_OFS: prdata_r <= {24'h0, edge_select_reg_r};
            `VIC_PER0_OFS: prdata_r <= {24'h0, period0_control_reg_r};
            `VIC_PER1_OFS: prdata_r <= {24'h0, period1_control_reg_r};
            `VIC_PSC_OFS: prdata_r <= {30'h0, psc_en_r};
            `VIC_VEC_OFS: prdata_r <= {27'h0, irq_req, irq_vector};
            default: prdata_r <= 32'h00000000;
         endcase
      end
   end
   wire unused_rd = rd_en;
endmodule // vic_top

/* File: include/vic_consts.vh */
// Constants of the vectored interrupt controller: register offsets, fields, vectors
`ifndef VIC_CONSTS_VH
`define VIC_CONSTS_VH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define VIC_CTRL0_OFS 12'h000
`define VIC_CTRL1_OFS 12'h004
`define VIC_CTRL2_OFS 12'h008
`define VIC_GRP0_OFS 12'h00C
`define VIC_GRP1_OFS 12'h010
`define VIC_GRP2_OFS 12'h014
`define VIC_EDGE_OFS 12'h018
`define VIC_PER0_OFS 12'h01C
`define VIC_PER1_OFS 12'h020
`define VIC_PSC_OFS 12'h024
`define VIC_VEC_OFS 12'h028
// ****************************************************************
// Edge select codes, two bits per pin
// ****************************************************************
`define VIC_EDGE_OFF 2'h0
`define VIC_EDGE_RISE 2'h1
`define VIC_EDGE_FALL 2'h2
`define VIC_EDGE_BOTH 2'h3
// ****************************************************************
// Vector numbers in priority order, lowest number wins
// ****************************************************************
`define VIC_VEC_INT0 4'h0
`define VIC_VEC_INT1 4'h1
`define VIC_VEC_SER 4'h2
`define VIC_VEC_SPI2 4'h3
`define VIC_VEC_MF0 4'h4
`define VIC_VEC_MF1 4'h5
`define VIC_VEC_MF2 4'h6
`define VIC_VEC_TB0 4'h7
`define VIC_VEC_TB1 4'h8
`define VIC_VEC_INT2 4'h9
`define VIC_VEC_INT3 4'hA
`define VIC_NUM_VEC 11
// ****************************************************************
// Time base
// ****************************************************************
`define VIC_XTAL_PRE_DIV 3'h7
`define VIC_PER_BASE_LOG2 8
`define VIC_RESET_VAL 8'h00
`endif

/* File: verif/vic_checker_assertions.sv */
// Port-level checker for request, service and bus timing of the controller
`timescale 1ns/1ns
`include "vic_consts.vh"
module vic_checker (
   // APB side
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   // Core side
   input wire stack_full,
   input wire irq_ack,
   input wire return_from_irq_instr,
   input wire irq_req,
   input wire [3:0] irq_vector,
   input wire wake_up
);
   // ****************************************************************
   // Shadow of the global enable; service wins over a same-cycle write
   // ****************************************************************
   wire wr_ctl0 = psel && penable && pwrite && paddr == `VIC_CTRL0_OFS;
   wire bad_addr = paddr > `VIC_VEC_OFS || paddr[1:0] != 2'h0;
   wire bus_wr = psel && penable && pwrite;
   wire drop_cause = irq_ack || stack_full;
   reg glob_r;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) glob_r <= 1'b0;
      else if (irq_req && irq_ack) glob_r <= 1'b0;
      else if (return_from_irq_instr) glob_r <= 1'b1;
      else if (wr_ctl0) glob_r <= pwdata[0];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_ack_drops_req: assert property (irq_req && irq_ack |=> !irq_req)
      else $error("request stayed high after service");
   chk_room_for_call: assert property ($rose(irq_req) |-> !$past(stack_full))
      else $error("request raised while stack full");
   chk_global_gates: assert property ($rose(irq_req) |-> $past(glob_r))
      else $error("request raised with global enable clear");
   chk_plain_return: assert property (irq_req && irq_ack ##1 !return_from_irq_instr && !wr_ctl0 |=> ##1 !irq_req)
      else $error("request came back without a return");
   chk_drop_has_cause: assert property ($fell(irq_req) |-> $past(drop_cause) || $past(bus_wr, 2))
      else $error("request withdrawn without service or write");
   chk_vector_legal: assert property (irq_req |-> irq_vector < 4'hB)
      else $error("vector number out of range");
   chk_zero_wait: assert property (psel && penable |-> pready)
      else $error("bus access stalled");
   chk_bad_addr_err: assert property (psel && penable |-> pslverr == bad_addr)
      else $error("slave error does not match address");
   cover property (irq_req && irq_ack);
   cover property (wake_up);
   cover property (psel && penable && pslverr);
endmodule // vic_checker
bind vic_top vic_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .stack_full(stack_full), .irq_ack(irq_ack), .return_from_irq_instr(return_from_irq_instr),
   .irq_req(irq_req), .irq_vector(irq_vector), .wake_up(wake_up));

/* File: verif/vic_core_model.sv */
// Behavioural core sequencer that takes vector calls from the controller
`timescale 1ns/1ns
module vic_core_model (
   // Clock and reset
   input wire pclk,
   input wire presetn,
   // Request and wait setting
   input wire irq_req,
   input wire [3:0] irq_vector,
   input wire [3:0] ack_dly,
   // Service handshake and record
   output reg irq_ack,
   output reg [3:0] last_vec,
   output int n_taken
);
   reg [3:0] wait_r;
   // Ack after a programmable wait so prompt and slow cores are both seen
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ack <= 1'b0;
         wait_r <= 4'h0;
         last_vec <= 4'h0;
         n_taken <= 0;
      end else begin
         irq_ack <= irq_req && !irq_ack && wait_r >= ack_dly;
         wait_r <= (irq_req && !irq_ack) ? wait_r + 4'h1 : 4'h0;
         // vector taken at the ack edge
         if (irq_req && irq_ack) begin
            last_vec <= irq_vector;
            n_taken <= n_taken + 1;
         end
      end
   end
endmodule // vic_core_model

/* File: verif/vic_top_tb_top.sv */
// Testbench driving the interrupt controller over APB and its event inputs
`timescale 1ns/1ns
`include "vic_consts.vh"
module vic_top_tb_top;
   // ****************************************************************
   // Stimulus, bus tasks and checks
   // ****************************************************************
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, rerr, irq_ack, irq_req, wake_up, tick = 1'b0;
   logic stack_full = 1'b0, return_from_irq_instr = 1'b0;
   logic [3:0] irq_pin = 4'h0, ack_dly = 4'h0, irq_vector, last_vec;
   logic [18:0] ev = 19'h0;
   int num_errors = 0, samples_checked = 0, n_wake = 0, cyc = 0, stamp = 0, t0, n_taken;
   vic_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .irq_pin(irq_pin), .tmr_match_evt(ev[5:0]), .supply_low_evt(ev[6]), .nvm_write_done_evt(ev[7]),
      .serial_sync_evt(ev[11:8]), .uart_evt(ev[17:12]), .second_serial_evt(ev[18]),
      .low_speed_crystal_tick(tick), .stack_full(stack_full), .irq_ack(irq_ack),
      .return_from_irq_instr(return_from_irq_instr), .irq_req(irq_req), .irq_vector(irq_vector),
      .wake_up(wake_up));
   vic_core_model u_core (.pclk(pclk), .presetn(presetn), .irq_req(irq_req), .irq_vector(irq_vector),
      .ack_dly(ack_dly), .irq_ack(irq_ack), .last_vec(last_vec), .n_taken(n_taken));
   // Clock; crystal tick every second cycle keeps period sums exact
   always #5 pclk = ~pclk;
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      tick <= ~tick;
      if (wake_up === 1'b1) n_wake <= n_wake + 1;
   end
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; request held until pready is sampled high
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, rdat, e);
   endtask
   task fire(input logic [18:0] m);
      ev <= m;
      @(posedge pclk);
      ev <= 19'h0;
      @(posedge pclk);
   endtask
   task irq_return;
      return_from_irq_instr <= 1'b1;
      @(posedge pclk);
      return_from_irq_instr <= 1'b0;
      @(posedge pclk);
   endtask
   // Wait for the next call under a bound, then compare its vector
   task take(input logic [3:0] v);
      int n, t;
      n = 0;
      t = n_taken;
      while (n_taken == t && n < 20000) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20000) num_errors++;
      stamp = cyc;
      chk("vector", {28'h0, last_vec}, {28'h0, v});
   endtask
   task idle;
      int t;
      t = n_taken;
      repeat (20) @(posedge pclk);
      chk("no call", n_taken, t);
   endtask
   task finish_test;
      $display("checks %0d errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Hang guard, well above the longest period wait
   initial begin
      #700000;
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 11; i++) rd("reset value", 12'(i * 4), 32'h0);
      rd("unmapped", 12'h02C, 32'h0);
      chk("slave error", rerr, 32'h1);
      // Pins: rise, fall, both, off
      wr(`VIC_EDGE_OFS, 32'h39);
      irq_pin <= 4'hF;
      repeat (4) @(posedge pclk);
      rd("pins up low", `VIC_CTRL0_OFS, 32'h10);
      rd("pins up high", `VIC_CTRL2_OFS, 32'h40);
      irq_pin <= 4'h0;
      repeat (4) @(posedge pclk);
      rd("pins down low", `VIC_CTRL0_OFS, 32'h30);
      rd("pins down high", `VIC_CTRL2_OFS, 32'h40);
      chk("wake pulses", n_wake, 32'h2);
      wr(`VIC_CTRL0_OFS, 32'h37);
      take(4'h0);
      rd("pin0 served", `VIC_CTRL0_OFS, 32'h26);
      irq_return;
      take(4'h1);
      ack_dly <= 4'h6;
      wr(`VIC_CTRL2_OFS, 32'h44);
      stack_full <= 1'b1;
      irq_return;
      idle;
      stack_full <= 1'b0;
      take(4'h9);
      rd("pin2 served", `VIC_CTRL2_OFS, 32'h04);
      // Group of the first four timer matches, then supply low and write done; members outlive the service
      wr(`VIC_GRP0_OFS, 32'h02);
      fire(19'h00003);
      rd("timer flags", `VIC_GRP0_OFS, 32'h32);
      rd("group flag", `VIC_CTRL1_OFS, 32'h20);
      wr(`VIC_CTRL1_OFS, 32'h22);
      idle;
      irq_return;
      take(4'h4);
      rd("group served", `VIC_CTRL1_OFS, 32'h02);
      rd("members kept", `VIC_GRP0_OFS, 32'h32);
      wr(`VIC_GRP0_OFS, 32'h02);
      irq_return;
      fire(19'h00001);
      idle;
      wr(`VIC_GRP2_OFS, 32'h03);
      wr(`VIC_CTRL1_OFS, 32'h08);
      fire(19'h00040);
      take(4'h6);
      rd("supply low kept", `VIC_GRP2_OFS, 32'h13);
      irq_return;
      fire(19'h00080);
      take(4'h6);
      rd("write done kept", `VIC_GRP2_OFS, 32'h33);
      // Every serial module event, one at a time
      wr(`VIC_CTRL1_OFS, 32'h00);
      wr(`VIC_CTRL0_OFS, 32'h08);
      for (int i = 8; i < 18; i++) begin
         irq_return;
         fire(19'h1 << i);
         take(4'h2);
         rd("serial served", `VIC_CTRL0_OFS, 32'h08);
      end
      // Two sources at once: lower vector first, other stays pending
      irq_return;
      wr(`VIC_CTRL0_OFS, 32'h08);
      wr(`VIC_CTRL1_OFS, 32'h01);
      fire(19'h41000);
      wr(`VIC_CTRL0_OFS, 32'h49);
      take(4'h2);
      irq_return;
      take(4'h3);
      rd("second served", `VIC_CTRL1_OFS, 32'h01);
      // Time bases: period is 8 * 2^(8+sel) ticks of two cycles each
      wr(`VIC_PSC_OFS, 32'h03);
      for (int k = 0; k < 2; k++) begin
         wr(`VIC_PER0_OFS + 12'(4 * k), 32'h80 | k);
         wr(`VIC_CTRL2_OFS, 32'h1 << k);
         irq_return;
         take(4'(7 + k));
         irq_return;
         take(4'(7 + k));
         t0 = stamp;
         irq_return;
         take(4'(7 + k));
         chk("period cycles", stamp - t0, 32'(4096 << k));
         rd("period served", `VIC_CTRL2_OFS, 32'h1 << k);
         wr(`VIC_PER0_OFS + 12'(4 * k), 32'h0);
      end
      finish_test;
   end
endmodule // vic_top_tb_top
